// ===== acl_action_decode.sv
// decodes one action vector into a per-lookup decision
`timescale 1ns/1ps
module acl_action_decode import acl_pkg::*; (
   input wire action_s action,
   input wire logic second,
   input wire logic cnt_zero,
   output decision_s dec
);
   // single copy and copy-all share the queue field
   assign dec.copy = action.host_copy_all | (action.single_copy_to_host & cnt_zero);
   assign dec.queue = action.host_queue_select;
   assign dec.mirror = action.mirror_request;
   assign dec.learn_off = action.learning_suppress;
   assign dec.police = action.policer_apply & ~second;
   assign dec.police_sel = action.policer_index;
   assign dec.mode = action.mask_mode;
   assign dec.mask = action.port_mask;
endmodule : acl_action_decode

// ===== acl_cfg.svh
// constants for the security stage key and action logic
// Overview of operation
// - custom payload of 320 bits starts at byte 34, or byte 12 if origin bit set.
// - up to two vlan tags are skipped before counting payload offsets.
// - two lookups per frame, each yielding one action vector.
// - first lookup miss uses the ingress port's default action.
// - second lookup miss uses one default action common to all ports.
// - default actions are applied exactly like matched actions.
// - single copy to host only while match counter is zero, then counter increments.
// - copy-all sends every hitting frame to the selected host queue.
// - 3-bit host queue field at bit 2 picks the host queue.
// - mode at bit 5: none, and-mask, replace dmac result, replace all forwarding.
// - host port membership in destination set is never changed by the mode.
// - mirror bit sends a copy of hitting frames to mirror target ports.
// - learning suppress bit disables address learning for hitting frames.
// - policer apply honoured in first lookup only, ignored in second.
// - 9-bit policer index at bit 10 selects the policer.
// - 11-bit port set at bit 20 feeds the forwarding decision per mode.
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
`define KEY_ORIGIN_L3 7'h22
`define KEY_ORIGIN_SMAC 7'h0c
`define KEY_PAYLOAD_W 320
`define KEY_PAYLOAD_BYTES 40
`define VLAN_TAG_BYTES 7'h04
`define TPID_CTAG 16'h8100
`define TPID_STAG 16'h88a8
`define TAG0_POS 12
`define TAG1_POS 16
`define REG_CTRL 12'h000
`define REG_MIRROR 12'h004
`define REG_DEF2 12'h008
`define REG_STATUS 12'h00c
`define REG_PORTDEF 12'h040
`define REG_CNT 12'h400
`define CTRL_ORIGIN_BIT 0
`define CTRL_RST 1'b0
`define MIRROR_RST 11'h000
`define ACTION_RST 31'h00000000
`endif

// ===== acl_custom_key.sv
// custom key payload extraction with vlan tag skipping
`timescale 1ns/1ps
`include "acl_cfg.svh"
module acl_custom_key import acl_pkg::*; #(
   parameter int FRAME_BYTES = 82
) (
   input wire logic [FRAME_BYTES*8-1:0] frame,
   input wire logic origin_sel,
   output logic [`KEY_PAYLOAD_W-1:0] payload
);
   function automatic logic is_tpid(input logic [15:0] t);
      is_tpid = (t == `TPID_CTAG) || (t == `TPID_STAG);
   endfunction : is_tpid

   // tag field sits big-endian in the byte stream
   wire tag0 = is_tpid({frame[`TAG0_POS*8 +: 8], frame[(`TAG0_POS+1)*8 +: 8]});
   wire tag1 = tag0 & is_tpid({frame[`TAG1_POS*8 +: 8], frame[(`TAG1_POS+1)*8 +: 8]});
   wire [6:0] skip = tag1 ? 7'(2*`VLAN_TAG_BYTES) : (tag0 ? `VLAN_TAG_BYTES : 7'h00);
   wire [6:0] base = origin_sel ? `KEY_ORIGIN_SMAC : `KEY_ORIGIN_L3;
   wire [6:0] start = base + skip;

   genvar k;
   generate
      for (k = 0; k < `KEY_PAYLOAD_BYTES; k++) begin : g_byte
         assign payload[k*8 +: 8] = frame[(int'(start) + k)*8 +: 8];
      end
   endgenerate
endmodule : acl_custom_key

// ===== acl_fwd_sink.sv
// far side sink that files host copies per queue
`timescale 1ns/1ps
module acl_fwd_sink (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic res_valid,
   input wire logic cpu_copy,
   input wire logic [2:0] cpu_queue
);
   int copies [8];
   // queue only meaningful with a copy, so it is ignored otherwise
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         foreach (copies[q]) copies[q] <= 0;
      end else if (res_valid && cpu_copy) begin
         copies[cpu_queue] <= copies[cpu_queue] + 1;
      end
   end
endmodule : acl_fwd_sink

// ===== acl_pkg.sv
// types shared by the security stage logic
package acl_pkg;
   typedef enum logic [1:0] {
      MM_NONE = 2'h0,
      MM_PERMIT = 2'h1,
      MM_POLICY = 2'h2,
      MM_REDIRECT = 2'h3
   } mask_mode_e;
   typedef struct packed {
      logic [10:0] port_mask;
      logic spare;
      logic [8:0] policer_index;
      logic policer_apply;
      logic learning_suppress;
      logic mirror_request;
      mask_mode_e mask_mode;
      logic [2:0] host_queue_select;
      logic host_copy_all;
      logic single_copy_to_host;
   } action_s;
   typedef struct packed {
      logic copy;
      logic [2:0] queue;
      logic mirror;
      logic learn_off;
      logic police;
      logic [8:0] police_sel;
      mask_mode_e mode;
      logic [10:0] mask;
   } decision_s;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_RDWAIT = 2'h1,
      BUS_RDDONE = 2'h3
   } bus_state_e;
endpackage : acl_pkg

// ===== acl_stage_action_apply.sv
// security stage key build, action resolve and apply, with ahb-lite registers
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "acl_cfg.svh"
module acl_stage_action_apply import acl_pkg::*; #(
   parameter int PORTS = 11,
   parameter int ENTRIES = 64,
   parameter int CNT_W = 16,
   parameter int FRAME_BYTES = 82
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic FRM_VALID,
   input wire logic [FRAME_BYTES*8-1:0] FRM_DATA,
   output logic KEY_VALID,
   output logic KEY_ORIGIN,
   output logic [`KEY_PAYLOAD_W-1:0] KEY_PAYLOAD,
   input wire logic LK_VALID,
   input wire logic [3:0] LK_PORT,
   input wire logic [PORTS:0] FWD_PRE,
   input wire logic [PORTS:0] FWD_DMAC,
   input wire logic LK1_HIT,
   input wire logic [$clog2(ENTRIES)-1:0] LK1_IDX,
   input wire action_s LK1_ACTION,
   input wire logic LK2_HIT,
   input wire logic [$clog2(ENTRIES)-1:0] LK2_IDX,
   input wire action_s LK2_ACTION,
   output logic RES_VALID,
   output logic [PORTS:0] DEST_SET,
   output logic CPU_COPY,
   output logic [2:0] CPU_QUEUE,
   output logic [PORTS-1:0] MIRROR_SET,
   output logic LEARN_SUPPRESS,
   output logic POLICE,
   output logic [8:0] POLICE_INDEX
);
   localparam int NCNT = ENTRIES + PORTS + 1;
   localparam int CIDX_W = $clog2(NCNT);

   function automatic logic cnt_sel(input logic [11:0] a);
      cnt_sel = (a >= `REG_CNT) && (a < `REG_CNT + 12'(4*NCNT));
   endfunction : cnt_sel

   function automatic logic pdef_sel(input logic [11:0] a);
      pdef_sel = (a >= `REG_PORTDEF) && (a < `REG_PORTDEF + 12'(4*PORTS));
   endfunction : pdef_sel

   function automatic logic [PORTS-1:0] apply_mode(input logic [PORTS-1:0] dest, input logic [PORTS-1:0] pre,
                                                   input mask_mode_e mode, input logic [PORTS-1:0] mask);
      case (mode)
         MM_PERMIT: apply_mode = dest & mask;
         MM_POLICY: apply_mode = pre & mask;
         MM_REDIRECT: apply_mode = mask;
         default: apply_mode = dest;
      endcase
   endfunction : apply_mode

   // bus slave state
   bus_state_e state_q, state_d;
   logic wph_q;
   logic [11:0] addr_q;
   logic [31:0] rdata_q;
   logic [31:0] rmux;

   // configuration and status
   logic origin_q;
   logic [PORTS-1:0] mirror_q;
   action_s def2_q;
   action_s pdef_q [PORTS];
   logic [CNT_W-1:0] cnt_q [NCNT];
   logic [15:0] frames_q;

   wire take = HSEL & HREADY & HTRANS[1];
   wire wr_en = wph_q;
   wire [11:0] pdef_off = addr_q - `REG_PORTDEF;
   wire [11:0] cnt_off = addr_q - `REG_CNT;
   wire [3:0] wr_port = pdef_off[5:2];
   wire [CIDX_W-1:0] wr_cidx = CIDX_W'(cnt_off[11:2]);

   always_comb begin
      state_d = state_q;
      case (state_q)
         BUS_RDWAIT: state_d = BUS_RDDONE;
         default: state_d = (take & ~HWRITE) ? BUS_RDWAIT : BUS_IDLE;
      endcase
   end

   // one wait state on reads so a write just before is seen
   assign HREADYOUT = (state_q != BUS_RDWAIT);
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= BUS_IDLE;
         wph_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         state_q <= state_d;
         wph_q <= take & HWRITE;
         if (take) begin
            addr_q <= HADDR[11:0];
         end
      end
   end

   always_comb begin
      rmux = 32'h00000000;
      if (addr_q == `REG_CTRL) begin
         rmux[`CTRL_ORIGIN_BIT] = origin_q;
      end else if (addr_q == `REG_MIRROR) begin
         rmux[PORTS-1:0] = mirror_q;
      end else if (addr_q == `REG_DEF2) begin
         rmux[$bits(action_s)-1:0] = def2_q;
      end else if (addr_q == `REG_STATUS) begin
         rmux[15:0] = frames_q;
      end else if (pdef_sel(addr_q)) begin
         rmux[$bits(action_s)-1:0] = pdef_q[wr_port];
      end else if (cnt_sel(addr_q)) begin
         rmux[CNT_W-1:0] = cnt_q[wr_cidx];
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q <= 32'h00000000;
      end else if (state_q == BUS_RDWAIT) begin
         rdata_q <= rmux;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         origin_q <= `CTRL_RST;
         mirror_q <= `MIRROR_RST;
         def2_q <= `ACTION_RST;
      end else if (wr_en) begin
         if (addr_q == `REG_CTRL) begin
            origin_q <= HWDATA[`CTRL_ORIGIN_BIT];
         end else if (addr_q == `REG_MIRROR) begin
            mirror_q <= HWDATA[PORTS-1:0];
         end else if (addr_q == `REG_DEF2) begin
            def2_q <= HWDATA[$bits(action_s)-1:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_pdef
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               pdef_q[g] <= `ACTION_RST;
            end else if (wr_en && pdef_sel(addr_q) && wr_port == 4'(g)) begin
               pdef_q[g] <= HWDATA[$bits(action_s)-1:0];
            end
         end
      end
   endgenerate

   // key path
   logic [`KEY_PAYLOAD_W-1:0] payload;

   acl_custom_key #(
      .FRAME_BYTES(FRAME_BYTES)
   ) u_key (
      .frame(FRM_DATA),
      .origin_sel(origin_q),
      .payload(payload)
   );

   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         KEY_VALID <= 1'b0;
         KEY_ORIGIN <= 1'b0;
         KEY_PAYLOAD <= '0;
      end else begin
         KEY_VALID <= FRM_VALID;
         if (FRM_VALID) begin
            KEY_ORIGIN <= origin_q;
            KEY_PAYLOAD <= payload;
         end
      end
   end

   // action resolve; defaults get their own counters so they behave like entries
   wire [3:0] port = (LK_PORT < 4'(PORTS)) ? LK_PORT : 4'h0;
   wire action_s act1 = LK1_HIT ? LK1_ACTION : pdef_q[port];
   wire action_s act2 = LK2_HIT ? LK2_ACTION : def2_q;
   wire [CIDX_W-1:0] eidx1 = LK1_HIT ? CIDX_W'(LK1_IDX) : CIDX_W'(ENTRIES) + CIDX_W'(port);
   wire [CIDX_W-1:0] eidx2 = LK2_HIT ? CIDX_W'(LK2_IDX) : CIDX_W'(ENTRIES + PORTS);
   wire zero1 = (cnt_q[eidx1] == '0);
   wire zero2 = (cnt_q[eidx2] == '0);

   decision_s dec1;
   decision_s dec2;

   acl_action_decode u_dec1 (
      .action(act1),
      .second(1'b0),
      .cnt_zero(zero1),
      .dec(dec1)
   );

   acl_action_decode u_dec2 (
      .action(act2),
      .second(1'b1),
      .cnt_zero(zero2),
      .dec(dec2)
   );

   // counters saturate; a hit in the clear cycle still counts
   generate
      for (g = 0; g < NCNT; g++) begin : g_cnt
         wire inc = LK_VALID & ((eidx1 == CIDX_W'(g)) | (eidx2 == CIDX_W'(g)));
         wire clr = wr_en & cnt_sel(addr_q) & (wr_cidx == CIDX_W'(g));
         wire [CNT_W-1:0] nxt = clr ? CNT_W'(1) : ((&cnt_q[g]) ? cnt_q[g] : cnt_q[g] + CNT_W'(1));
         always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
               cnt_q[g] <= '0;
            end else if (inc) begin
               cnt_q[g] <= nxt;
            end else if (clr) begin
               cnt_q[g] <= '0;
            end
         end
      end
   endgenerate

   // forwarding: first lookup then second, host port bit left as it was
   wire [PORTS-1:0] pre = FWD_PRE[PORTS-1:0];
   wire [PORTS:0] dest0 = FWD_PRE & FWD_DMAC;
   wire [PORTS-1:0] dest1 = apply_mode(dest0[PORTS-1:0], pre, dec1.mode, dec1.mask[PORTS-1:0]);
   wire [PORTS-1:0] dest2 = apply_mode(dest1, pre, dec2.mode, dec2.mask[PORTS-1:0]);
   // larger queue wins when both lookups copy
   wire [2:0] queue = (dec1.copy && (!dec2.copy || dec1.queue > dec2.queue)) ? dec1.queue : dec2.queue;
   wire copy_any = dec1.copy | dec2.copy;
   wire mirror_any = dec1.mirror | dec2.mirror;
   wire learn_any = dec1.learn_off | dec2.learn_off;

   // result valid and frame count; status count wraps silently
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RES_VALID <= 1'b0;
         frames_q <= 16'h0000;
      end else begin
         RES_VALID <= LK_VALID;
         if (LK_VALID) begin
            frames_q <= frames_q + 16'h0001;
         end
      end
   end

   // result fields hold between frames so a slow consumer may sample late
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         DEST_SET <= '0;
      end else if (LK_VALID) begin
         DEST_SET <= {dest0[PORTS], dest2};
      end
   end

   // queue only meaningful while the copy flag is up
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         CPU_COPY <= 1'b0;
         CPU_QUEUE <= 3'h0;
      end else if (LK_VALID) begin
         CPU_COPY <= copy_any;
         CPU_QUEUE <= queue;
      end
   end

   // mirror targets sampled per frame, so a rewrite applies from the next one
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MIRROR_SET <= '0;
         LEARN_SUPPRESS <= 1'b0;
      end else if (LK_VALID) begin
         MIRROR_SET <= mirror_any ? mirror_q : '0;
         LEARN_SUPPRESS <= learn_any;
      end
   end

   // second lookup never polices, so only the first decision counts
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         POLICE <= 1'b0;
         POLICE_INDEX <= 9'h000;
      end else if (LK_VALID) begin
         POLICE <= dec1.police;
         POLICE_INDEX <= dec1.police_sel;
      end
   end
endmodule : acl_stage_action_apply

// ===== acl_stage_action_apply_tb_top.sv
// self-checking bench for the security stage block
`timescale 1ns/1ps
module acl_stage_action_apply_tb_top import acl_pkg::*;;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, HREADY, HREADYOUT, HRESP;
   logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd;
   logic [1:0] HTRANS = '0;
   logic [2:0] HSIZE = 3'h2, CPU_QUEUE;
   logic FRM_VALID = 1'b0, KEY_VALID, KEY_ORIGIN, LK_VALID = 1'b0, LK1_HIT = 1'b0, LK2_HIT = 1'b0;
   logic [655:0] FRM_DATA = '0;
   logic [319:0] KEY_PAYLOAD;
   logic [3:0] LK_PORT = '0;
   logic [11:0] FWD_PRE = '0, FWD_DMAC = '0, DEST_SET;
   logic [5:0] LK1_IDX = '0, LK2_IDX = '0;
   action_s LK1_ACTION = '0, LK2_ACTION = '0, def2, pdef [11];
   logic RES_VALID, CPU_COPY, LEARN_SUPPRESS, POLICE;
   logic [10:0] MIRROR_SET, mir;
   logic [8:0] POLICE_INDEX;
   int fail_count = 0, n_compared = 0, nres = 0, seed, cnt [76], ecopy [8];
   int idx [6] = '{0, 1, 2, 3, 64, 75};
   assign HREADY = HREADYOUT;
   always #12.5 SYS_CLK = ~SYS_CLK;
   acl_stage_action_apply i_acl_stage_action_apply (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FRM_VALID(FRM_VALID), .FRM_DATA(FRM_DATA), .KEY_VALID(KEY_VALID),
      .KEY_ORIGIN(KEY_ORIGIN), .KEY_PAYLOAD(KEY_PAYLOAD), .LK_VALID(LK_VALID), .LK_PORT(LK_PORT), .FWD_PRE(FWD_PRE),
      .FWD_DMAC(FWD_DMAC), .LK1_HIT(LK1_HIT), .LK1_IDX(LK1_IDX), .LK1_ACTION(LK1_ACTION), .LK2_HIT(LK2_HIT),
      .LK2_IDX(LK2_IDX), .LK2_ACTION(LK2_ACTION), .RES_VALID(RES_VALID), .DEST_SET(DEST_SET), .CPU_COPY(CPU_COPY),
      .CPU_QUEUE(CPU_QUEUE), .MIRROR_SET(MIRROR_SET), .LEARN_SUPPRESS(LEARN_SUPPRESS), .POLICE(POLICE),
      .POLICE_INDEX(POLICE_INDEX));
   acl_fwd_sink i_acl_fwd_sink (.clk(SYS_CLK), .rst_n(RST_N), .res_valid(RES_VALID), .cpu_copy(CPU_COPY),
      .cpu_queue(CPU_QUEUE));
   task automatic chk(input logic [319:0] seen, input logic [319:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic final_report;
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   // no wait count assumed: the watchdog ends a hung transfer
   task automatic ahb(input logic wr, input int a, input logic [31:0] wd);
      HSEL <= 1'b1; HADDR <= 32'(a); HWRITE <= wr; HTRANS <= 2'h2;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0; HWDATA <= wd;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : ahb
   task automatic frame(input logic org);
      logic [7:0] b [82];
      logic [319:0] exp;
      logic [655:0] fd;
      int nt, st;
      foreach (b[k]) b[k] = 8'($urandom);
      nt = $urandom % 3;
      b[12] = 8'h00;
      b[16] = 8'h00;
      if (nt > 0) {b[12], b[13]} = nt[0] ? 16'h8100 : 16'h88a8;
      if (nt > 1) {b[16], b[17]} = 16'h8100;
      st = (org ? 12 : 34) + 4 * nt;
      for (int j = 0; j < 40; j++) exp[8*j +: 8] = b[st + j];
      foreach (b[k]) fd[8*k +: 8] = b[k];
      FRM_VALID <= 1'b1; FRM_DATA <= fd;
      @(posedge SYS_CLK);
      FRM_VALID <= 1'b0;
      #1;
      chk(KEY_ORIGIN, org);
      chk(KEY_PAYLOAD, exp);
      @(posedge SYS_CLK);
   endtask : frame
   function automatic logic [10:0] apply(input logic [10:0] d, input logic [10:0] pre, input action_s a);
      case (a.mask_mode)
         MM_PERMIT: return d & a.port_mask;
         MM_POLICY: return pre & a.port_mask;
         MM_REDIRECT: return a.port_mask;
         default: return d;
      endcase
   endfunction : apply
   task automatic lookup;
      action_s a1, a2, x1, x2;
      logic h1, h2, c1, c2;
      logic [3:0] p;
      logic [5:0] e1, e2;
      logic [11:0] pre, dm, d;
      int i1, i2, pp;
      h1 = 1'($urandom); h2 = 1'($urandom); p = 4'($urandom); e1 = 6'($urandom % 4); e2 = 6'($urandom % 4);
      x1 = 31'($urandom); x2 = 31'($urandom); pre = 12'($urandom); dm = 12'($urandom);
      LK_VALID <= 1'b1; LK_PORT <= p; FWD_PRE <= pre; FWD_DMAC <= dm; LK1_HIT <= h1; LK1_IDX <= e1;
      LK1_ACTION <= x1; LK2_HIT <= h2; LK2_IDX <= e2; LK2_ACTION <= x2;
      pp = p < 11 ? p : 0;
      a1 = h1 ? x1 : pdef[pp];
      i1 = h1 ? e1 : 64 + pp;
      a2 = h2 ? x2 : def2;
      i2 = h2 ? e2 : 75;
      c1 = a1.host_copy_all | (a1.single_copy_to_host & (cnt[i1] == 0));
      c2 = a2.host_copy_all | (a2.single_copy_to_host & (cnt[i2] == 0));
      d = pre & dm;
      d[10:0] = apply(apply(d[10:0], pre[10:0], a1), pre[10:0], a2);
      if (cnt[i1] < 65535) cnt[i1]++;
      if (i2 != i1 && cnt[i2] < 65535) cnt[i2]++;
      nres++;
      @(posedge SYS_CLK);
      LK_VALID <= 1'b0;
      #1;
      chk(DEST_SET, d);
      chk(CPU_COPY, c1 | c2);
      if (c1 | c2) begin
         ecopy[(c1 && (!c2 || a1.host_queue_select >= a2.host_queue_select)) ? a1.host_queue_select :
            a2.host_queue_select]++;
      end
      chk(MIRROR_SET, (a1.mirror_request | a2.mirror_request) ? mir : 11'h000);
      chk(LEARN_SUPPRESS, a1.learning_suppress | a2.learning_suppress);
      chk(POLICE, a1.policer_apply);
      if (a1.policer_apply) chk(POLICE_INDEX, a1.policer_index);
      @(posedge SYS_CLK);
   endtask : lookup
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      fail_count++;
      final_report();
   end
   initial begin
      seed = $urandom(32'h6b10);
      repeat (4) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      @(posedge SYS_CLK);
      for (int i = 0; i < 76; i++) ahb(1'b1, 32'h400 + 4 * i, 32'h0);
      for (int i = 0; i < 76; i++) cnt[i] = 0;
      for (int p = 0; p < 11; p++) begin
         pdef[p] = 31'($urandom);
         ahb(1'b1, 32'h40 + 4 * p, {1'b0, pdef[p]});
      end
      def2 = 31'($urandom);
      mir = 11'($urandom);
      ahb(1'b1, 32'h8, {1'b0, def2});
      ahb(1'b1, 32'h4, {21'h0, mir});
      for (int o = 0; o < 2; o++) begin
         ahb(1'b1, 32'h0, 32'(o));
         repeat (8) frame(o[0]);
      end
      repeat (300) begin
         lookup();
         if ($urandom % 16 == 0) begin
            seed = $urandom % 4;
            ahb(1'b1, 32'h400 + 4 * seed, 32'h0);
            cnt[seed] = 0;
         end
      end
      ahb(1'b0, 32'hc, 32'h0);
      chk(rd, 32'(nres[15:0]));
      foreach (idx[k]) begin
         ahb(1'b0, 32'h400 + 4 * idx[k], 32'h0);
         chk(rd, 32'(cnt[idx[k]]));
         chk(HRESP, 1'b0);
      end
      foreach (ecopy[q]) chk(32'(i_acl_fwd_sink.copies[q]), 32'(ecopy[q]));
      final_report();
   end
endmodule : acl_stage_action_apply_tb_top

// ===== acl_stage_props.sv
// port assertions for the security stage block
`timescale 1ns/1ps
`include "acl_cfg.svh"
module acl_stage_props import acl_pkg::*; #(
   parameter int PORTS = 11
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic FRM_VALID,
   input wire logic KEY_VALID,
   input wire logic [`KEY_PAYLOAD_W-1:0] KEY_PAYLOAD,
   input wire logic LK_VALID,
   input wire logic [PORTS:0] FWD_PRE,
   input wire logic [PORTS:0] FWD_DMAC,
   input wire logic LK1_HIT,
   input wire action_s LK1_ACTION,
   input wire logic LK2_HIT,
   input wire action_s LK2_ACTION,
   input wire logic RES_VALID,
   input wire logic [PORTS:0] DEST_SET,
   input wire logic CPU_COPY,
   input wire logic [PORTS-1:0] MIRROR_SET,
   input wire logic LEARN_SUPPRESS,
   input wire logic POLICE,
   input wire logic [8:0] POLICE_INDEX
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   key_answer_a: assert property (FRM_VALID |=> KEY_VALID) else $error("key missing");
   key_hold_a: assert property (!FRM_VALID |=> !KEY_VALID && $stable(KEY_PAYLOAD)) else $error("key moved");
   res_answer_a: assert property (LK_VALID |=> RES_VALID) else $error("result missing");
   res_hold_a: assert property (!LK_VALID |=> !RES_VALID && $stable(DEST_SET) && $stable(MIRROR_SET))
      else $error("result moved");
   host_bit_a: assert property (LK_VALID |=> DEST_SET[PORTS] == ($past(FWD_PRE[PORTS]) & $past(FWD_DMAC[PORTS])))
      else $error("host bit changed");
   police_index_a: assert property (LK_VALID && LK1_HIT && LK1_ACTION.policer_apply |=>
      POLICE && POLICE_INDEX == $past(LK1_ACTION.policer_index)) else $error("policer index wrong");
   police_off_a: assert property (LK_VALID && LK1_HIT && !LK1_ACTION.policer_apply |=> !POLICE)
      else $error("policing not off");
   copy_all_a: assert property (LK_VALID && ((LK1_HIT && LK1_ACTION.host_copy_all) ||
      (LK2_HIT && LK2_ACTION.host_copy_all)) |=> CPU_COPY) else $error("copy missing");
   learn_off_a: assert property (LK_VALID && LK2_HIT && LK2_ACTION.learning_suppress |=> LEARN_SUPPRESS)
      else $error("learning not off");
   mirror_none_a: assert property (LK_VALID && LK1_HIT && LK2_HIT && !LK1_ACTION.mirror_request &&
      !LK2_ACTION.mirror_request |=> MIRROR_SET == '0) else $error("stray mirror");
endmodule : acl_stage_props
bind acl_stage_action_apply acl_stage_props #(.PORTS(PORTS)) i_acl_stage_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .FRM_VALID(FRM_VALID), .KEY_VALID(KEY_VALID), .KEY_PAYLOAD(KEY_PAYLOAD), .LK_VALID(LK_VALID),
   .FWD_PRE(FWD_PRE), .FWD_DMAC(FWD_DMAC), .LK1_HIT(LK1_HIT), .LK1_ACTION(LK1_ACTION), .LK2_HIT(LK2_HIT),
   .LK2_ACTION(LK2_ACTION), .RES_VALID(RES_VALID), .DEST_SET(DEST_SET), .CPU_COPY(CPU_COPY),
   .MIRROR_SET(MIRROR_SET), .LEARN_SUPPRESS(LEARN_SUPPRESS), .POLICE(POLICE), .POLICE_INDEX(POLICE_INDEX));
